// File: verilog/psw_consts.vh
// Purpose: constants for the program status word flag register.
// Assumes: one 8-bit special register at a fixed address, bit addressable.
// Notes: arithmetic op codes are issued by the core decoder.
// Overview of operation
// - Add, add-with-carry, subtract-with-borrow set overflow on signed result overflow.
// - Multiply sets overflow when the product exceeds 255.
// - Divide by a zero divisor sets overflow.
// - These five ops clear overflow otherwise; other ops keep it.
// - Bank select is bits 4 and 3, bit 4 the upper bit.
// - Bank n maps Rn to base 8 times bank plus register number.
`ifndef PSW_CONSTS_VH
`define PSW_CONSTS_VH
`define PSW_ADDR 8'hD0
`define PSW_RESET 8'h00
`define PSW_BIT_CARRY 7
`define PSW_BIT_NIBBLE 6
`define PSW_BIT_USER0 5
`define PSW_BIT_BANKHI 4
`define PSW_BIT_BANKLO 3
`define PSW_BIT_OVER 2
`define PSW_BIT_USER1 1
`define PSW_BIT_PARITY 0
`define PSW_OP_NONE 3'h0
`define PSW_OP_ADD 3'h1
`define PSW_OP_ADDC 3'h2
`define PSW_OP_SUBB 3'h3
`define PSW_OP_MUL 3'h4
`define PSW_OP_DIV 3'h5
`define PSW_OP_OTHER 3'h6
`define PSW_MUL_LIMIT 16'h00FF
`endif

// File: verilog/psw_flags.v
// Purpose: program status word flags, register bank select and parity.
// Assumes: operands presented with a one-cycle op strobe; software writes by byte or bit.
// Notes: hardware flag update wins over a software write in the same cycle.
`timescale 1ns/1ps
`include "psw_consts.vh"
module psw_flags
(
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Arithmetic unit
    input wire [2:0] aluOp,
    input wire [7:0] opA,
    input wire [7:0] opB,
    input wire [7:0] accValue,
    // Special register access
    input wire [7:0] sfrAddr,
    input wire sfrWrite,
    input wire [7:0] sfrWdata,
    input wire bitWrite,
    input wire [2:0] bitSel,
    input wire bitValue,
    // Register operand resolution
    input wire [2:0] regNum,
    // Outputs
    output reg [7:0] pswValue_ff,
    output reg [7:0] regAddr_ff
);
    // Value as software leaves it this cycle
    reg [7:0] swValue;

    // Add and subtract results
    reg [8:0] sum;
    reg [4:0] nib;
    reg cin;
    reg asCarry;
    reg asNibble;
    reg asOver;

    // Multiply and divide results
    reg [15:0] prod;
    reg mdOver;

    // Merged next value of the register
    reg [7:0] nxt_pswValue;

    // Running parity over the accumulator bits
    wire [7:0] parityChain;

    // Decoded requests
    wire sfrHit;
    wire isAddSub;
    wire isMulDiv;
    wire [1:0] bankSel;

    // Address decode: only the flag register address is answered
    assign sfrHit = (sfrAddr == `PSW_ADDR);

    // Op classes that own the arithmetic flags
    assign isAddSub = (aluOp == `PSW_OP_ADD)
        || (aluOp == `PSW_OP_ADDC)
        || (aluOp == `PSW_OP_SUBB);
    assign isMulDiv = (aluOp == `PSW_OP_MUL)
        || (aluOp == `PSW_OP_DIV);

    // Software write path: a byte write beats a bit write
    always @*
    begin
        swValue = pswValue_ff;
        if (sfrHit && sfrWrite)
        begin
            swValue = sfrWdata;
        end
        else if (sfrHit && bitWrite)
        begin
            swValue[bitSel] = bitValue;
        end
    end

    // Carry in: plain add starts from zero, the others chain the carry
    always @*
    begin
        if (aluOp == `PSW_OP_ADD)
        begin
            cin = 1'b0;
        end
        else
        begin
            cin = pswValue_ff[`PSW_BIT_CARRY];
        end
    end

    // Add and subtract flag results
    always @*
    begin
        sum = 9'h000;
        nib = 5'h00;
        asCarry = 1'b0;
        asNibble = 1'b0;
        asOver = 1'b0;
        case (aluOp)
            `PSW_OP_ADD, `PSW_OP_ADDC:
            begin
                sum = {1'b0, opA} + {1'b0, opB} + {8'h00, cin};
                nib = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
                asCarry = sum[8];
                asNibble = nib[4];
                // Same operand signs but a different result sign
                asOver = (opA[7] == opB[7]) && (sum[7] != opA[7]);
            end
            `PSW_OP_SUBB:
            begin
                sum = {1'b0, opA} - {1'b0, opB} - {8'h00, cin};
                nib = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, cin};
                asCarry = sum[8];
                asNibble = nib[4];
                // Operand signs differ and the result took the subtrahend sign
                asOver = (opA[7] != opB[7]) && (sum[7] != opA[7]);
            end
            default:
            begin
                asCarry = 1'b0;
                asNibble = 1'b0;
                asOver = 1'b0;
            end
        endcase
    end

    // Multiply and divide overflow
    always @*
    begin
        prod = {8'h00, opA} * {8'h00, opB};
        case (aluOp)
            `PSW_OP_MUL:
            begin
                // Any bit in the upper product byte
                mdOver = (prod > `PSW_MUL_LIMIT);
            end
            `PSW_OP_DIV:
            begin
                // A zero divisor leaves no defined quotient
                mdOver = (opB == 8'h00);
            end
            default:
            begin
                mdOver = 1'b0;
            end
        endcase
    end

    // Parity chain, one stage per accumulator bit
    assign parityChain[0] = accValue[0];
    genvar gi;
    generate
        for (gi = 1; gi < 8; gi = gi + 1)
        begin : g_parity
            assign parityChain[gi] = parityChain[gi - 1] ^ accValue[gi];
        end
    endgenerate

    // Merge: hardware flags win over software in the same cycle
    always @*
    begin
        nxt_pswValue = swValue;
        if (isAddSub)
        begin
            nxt_pswValue[`PSW_BIT_CARRY] = asCarry;
            nxt_pswValue[`PSW_BIT_NIBBLE] = asNibble;
            nxt_pswValue[`PSW_BIT_OVER] = asOver;
        end
        else if (isMulDiv)
        begin
            nxt_pswValue[`PSW_BIT_CARRY] = 1'b0;
            nxt_pswValue[`PSW_BIT_NIBBLE] = 1'b0;
            nxt_pswValue[`PSW_BIT_OVER] = mdOver;
        end
        else
        begin
            // No op or any other op: overflow keeps the software value
            nxt_pswValue[`PSW_BIT_OVER] = swValue[`PSW_BIT_OVER];
        end
        // Parity is read only, so a write to it never sticks
        nxt_pswValue[`PSW_BIT_PARITY] = parityChain[7];
    end

    // Bank select taken from the value being loaded, so a write acts at once
    assign bankSel = nxt_pswValue[`PSW_BIT_BANKHI:`PSW_BIT_BANKLO];

    // Flag register and resolved register address
    always @(posedge mclk)
    begin
        if (srst)
        begin
            pswValue_ff <= `PSW_RESET;
            regAddr_ff <= 8'h00;
        end
        else
        begin
            pswValue_ff <= nxt_pswValue;
            // Bank base is eight times the bank, plus the register number
            regAddr_ff <= {3'h0, bankSel, regNum};
        end
    end

    // Limitations for users of this block:
    // the op strobe is a level, so holding aluOp repeats the flag update,
    // and a multi-cycle instruction must present its op for one cycle only.
    // Software sees its own write of the arithmetic bits lost whenever an
    // arithmetic op lands in the same cycle; this keeps the core's view
    // of the flags consistent with the result it has just produced.
    // Bit 0 can be written but always reloads from the accumulator parity.
endmodule

// File: verification/psw_monitor.sv
// Purpose: flag checks
// Assumes: bound to psw_flags
// Notes: flags land one edge late
`timescale 1ns/1ps
module psw_monitor
(
    // Watched ports
    input wire mclk,
    input wire srst,
    input wire [2:0] aluOp,
    input wire [7:0] opA,
    input wire [7:0] opB,
    input wire [2:0] regNum,
    input wire [7:0] accValue,
    input wire sfrWrite,
    input wire bitWrite,
    input wire [7:0] pswValue_ff,
    input wire [7:0] regAddr_ff
);
    // Expected add flags and product
    wire [8:0] sum = opA + opB;
    wire [4:0] low = opA[3:0] + opB[3:0];
    wire [2:0] addF = {sum[8], low[4], (opA[7] ~^ opB[7]) & (opA[7] ^ sum[7])};
    wire [15:0] prod = opA * opB;
    wire [8:0] dif = {1'b0, opA} - {1'b0, opB} - {8'h00, pswValue_ff[7]};
    wire [4:0] lowD = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, pswValue_ff[7]};
    wire [2:0] subF = {dif[8], lowD[4], (opA[7] ^ opB[7]) & (opA[7] ^ dif[7])};
    wire quiet = (aluOp == 3'h0 || aluOp == 3'h6) && !sfrWrite && !bitWrite;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    a_add_flags: assert property (aluOp == 3'h1 |=>
        {pswValue_ff[7:6], pswValue_ff[2]} == $past(addF)) else $error("add");
    a_mul_ovf: assert property (aluOp == 3'h4 |=>
        pswValue_ff[2] == ($past(prod) > 16'h00FF)) else $error("mul");
    a_div_zero: assert property (aluOp == 3'h5 |=>
        pswValue_ff[2] == ($past(opB) == 8'h00)) else $error("div");
    a_bank_addr: assert property (1'b1 |=>
        regAddr_ff == {3'h0, pswValue_ff[4:3], $past(regNum)}) else $error("bank");
    a_subb_flags: assert property (aluOp == 3'h3 |=>
        {pswValue_ff[7:6], pswValue_ff[2]} == $past(subF)) else $error("subb");
    a_keep_ovf: assert property (quiet |=>
        pswValue_ff[2] == $past(pswValue_ff[2])) else $error("keep");
    a_parity_acc: assert property (1'b1 |=>
        pswValue_ff[0] == $past(^accValue)) else $error("parity");
endmodule
bind psw_flags psw_monitor psw_monitor_i (.mclk, .srst, .aluOp, .opA, .opB, .regNum,
    .accValue, .sfrWrite, .bitWrite,
    .pswValue_ff, .regAddr_ff);

// File: verification/psw_core_model.sv
// Purpose: core issuing ops
// Assumes: one request a cycle
// Notes: op is op code, a, b
`timescale 1ns/1ps
module psw_core_model
(
    // Clock and request
    input wire mclk,
    input wire [18:0] req,
    // Op to the flags
    output reg [18:0] op = 19'h00000
);
    // Launch just after the edge
    always @(posedge mclk)
        op <= #1 req;
endmodule

// File: verification/psw_flags_test.sv
// Purpose: flag register test
// Assumes: ops come via the core model
// Notes: row is op, a, b, carry, nibble, overflow
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; $display("mismatch %0t bad value", $time); end end
module psw_flags_test;
    reg mclk = 0, srst = 1, sfrWrite = 0, bitWrite = 0;
    reg [2:0] regNum = 3'h7;
    reg [7:0] accValue = 8'h00;
    reg [18:0] req = 0;
    reg [21:0] rows [0:8];
    wire [18:0] op;
    wire [7:0] psw, ra;
    int checked = 0, mismatches = 0;
    psw_core_model psw_core_model_i (.mclk, .req, .op);
    psw_flags psw_flags_i (.mclk, .srst, .aluOp(op[18:16]), .opA(op[15:8]), .opB(op[7:0]),
        .accValue, .sfrAddr(8'hD0), .sfrWrite, .sfrWdata(8'h10), .bitWrite,
        .bitSel(3'h3), .bitValue(1'b1), .regNum, .pswValue_ff(psw), .regAddr_ff(ra));
    always #2.5 mclk = ~mclk;
    task stop_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        rows = '{{3'h1, 16'h7F01, 3'h3}, {3'h1, 16'hFF01, 3'h6}, {3'h2, 16'h0F00, 3'h2},
            {3'h4, 16'h1010, 3'h1}, {3'h4, 16'h0F11, 3'h0}, {3'h5, 16'h0500, 3'h1},
            {3'h6, 16'h0000, 3'h1}, {3'h3, 16'h8001, 3'h3}, {3'h2, 16'h0101, 3'h0}};
        repeat (16) @(posedge mclk);
        #1 srst = 0;
        `CHK(psw, 8'h00)
        for (int i = 0; i < 9; i++)
        begin
            req = rows[i][21:3];
            @(posedge mclk) #1 req = 0;
            @(posedge mclk) #1;
            `CHK({psw[7:6], psw[2]}, rows[i][2:0])
        end
        $display("rows done");
        sfrWrite = 1;
        @(posedge mclk) #1 sfrWrite = 0;
        `CHK(ra, 8'h17)
        bitWrite = 1;
        @(posedge mclk) #1 bitWrite = 0;
        `CHK(ra, 8'h1F)
        $display("bank done");
        accValue = 8'h07;
        @(posedge mclk) #1;
        `CHK(psw, 8'h19)
        $display("parity done");
        stop_test;
    end
endmodule
